// ==== hdl/iwft_pkg.sv ====
`default_nettype none
package iwft_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_START_ROW = 8'h00;
  localparam logic [7:0] IDX_START_COLUMN = 8'h02;
  localparam logic [7:0] IDX_WINDOW_HEIGHT = 8'h04;
  localparam logic [7:0] IDX_WINDOW_WIDTH = 8'h06;
  localparam logic [7:0] IDX_LINE_BLANKING = 8'h08;
  localparam logic [7:0] IDX_PART_IDENTITY = 8'h0A;
  localparam logic [7:0] IDX_SILICON_REVISION = 8'h0B;
  localparam logic [7:0] IDX_FRAME_BLANKING_ROWS = 8'h0C;
  localparam logic [7:0] IDX_EXPOSURE_ROWS = 8'h0E;
  localparam logic [7:0] IDX_SYNC_CTRL = 8'h7F;
  localparam logic [7:0] IDX_REPLACED_PIXEL_COUNT = 8'hA0;
  localparam logic [7:0] IDX_CURRENT_OUTPUT_ROW = 8'hA1;
  localparam logic [7:0] IDX_DARK_VARIANCE_HIGH = 8'hA2;
  localparam logic [7:0] IDX_DARK_VARIANCE_LOW = 8'hA3;
  localparam logic [7:0] IDX_ACTIVE_ROWS_HIGH = 8'hA4;
  localparam logic [7:0] IDX_ACTIVE_ROWS_LOW = 8'hA5;
  localparam logic [7:0] IDX_ACTIVE_COLUMNS_HIGH = 8'hA6;
  localparam logic [7:0] IDX_ACTIVE_COLUMNS_LOW = 8'hA7;
  localparam logic [7:0] IDX_COLUMN_COUNTER_HIGH = 8'hA8;
  localparam logic [7:0] IDX_COLUMN_COUNTER_LOW = 8'hA9;
  localparam logic [7:0] IDX_AUTO_EXPOSURE_ROWS_HIGH = 8'hAA;
  localparam logic [7:0] IDX_AUTO_EXPOSURE_ROWS_LOW = 8'hAB;
  localparam logic [7:0] IDX_PART_IDENTITY_INVERTED = 8'hFF;
  // Bus address bits that carry the index
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_IDX_MSB = 9;
  // Writable field masks; reserved bits stay zero
  localparam logic [15:0] MASK_12 = 16'h0FFF;
  localparam logic [15:0] MASK_11 = 16'h07FF;
  localparam logic [15:0] MASK_SYNC = 16'h0001;
  // Reset values
  localparam logic [15:0] RST_START_ROW = 16'h000C;
  localparam logic [15:0] RST_START_COLUMN = 16'h000C;
  localparam logic [15:0] RST_WINDOW_HEIGHT = 16'h0613;
  localparam logic [15:0] RST_WINDOW_WIDTH = 16'h0813;
  localparam logic [15:0] RST_FRAME_BLANKING_ROWS = 16'h0010;
  localparam logic [15:0] RST_EXPOSURE_ROWS = 16'h00F0;
  localparam logic [15:0] RST_SYNC_CTRL = 16'h0000;
  // Field widths and positions
  localparam int FLD_W = 12;
  localparam int ROW_MSB_LO = 4;
  localparam int BYTE_HI_LSB = 8;
  localparam int SYNC_HOLD_BIT = 0;
  localparam int CNT_W = 14;
  localparam int PIX_W = 12;
endpackage
`default_nettype wire

// ==== hdl/iwft_timing_regs.sv ====
// Our own choice: register access over Wishbone.
`default_nettype none
// How it works
// [RULE1] Twelve-bit start row, reset 12, high nibble plus low byte.
// [RULE2] Twelve-bit start column, reset 12, high nibble plus low byte.
// [RULE3] Readout begins at the programmed start row and column.
// [RULE4] Twelve-bit window height, reset 1555, rows in the active window.
// [RULE5] Software keeps bit 0 of height and width cleared.
// [RULE6] Frame period grows with rows read; fewer rows, faster frames.
// [RULE7] Twelve-bit window width, reset 2067, active pixels per row.
// [RULE8] Row timing fixed for any width; only window columns go out.
// [RULE9] Eleven-bit line blanking, three high bits plus low byte.
// [RULE10] Software should leave line blanking at its default.
// [RULE11] Read-only identity byte and its ones complement at index FF.
// [RULE12] Read-only eight-bit silicon revision.
// [RULE13] Twelve-bit frame blanking rows, reset 16, each adds one row time.
// [RULE14] Software programs at least eight frame blanking rows.
// [RULE15] Twelve-bit exposure in row times, reset 240.
// [RULE16] Exposure writes any time; sampled at first bottom dark row.
// [RULE17] Software routes exposure updates through the sync control.
// [RULE18] Manual exposure ignored while automatic exposure is on.
// [RULE19] Software limits exposure increases to dark plus blanking rows.
// [RULE20] Any exposure decrease is accepted without a split frame.
// [RULE21] Status byte shows eight MSBs of the row being output.
// [RULE22] Status bytes show replaced pixels, active rows and columns.
// [RULE23] Synced configuration takes effect only at a frame boundary.
// [RULE24] Reserved upper bits read zero and ignore writes.
module iwft_timing_regs #(
  parameter int ARRAY_START_COLUMN = 2080,
  parameter int DARK_BOTTOM_ROWS = 4,
  parameter logic [15:0] LINE_BLANK_RST = 16'h00A0,
  parameter logic [7:0] PART_ID = 8'h5A,
  parameter logic [7:0] SILICON_REV = 8'h03
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic auto_exposure_en_i,
  input wire logic [iwft_pkg::FLD_W-1:0] auto_exposure_rows_i,
  input wire logic [7:0] replaced_pixel_count_i,
  input wire logic [15:0] dark_variance_i,
  input wire logic [iwft_pkg::PIX_W-1:0] pixel_i,
  output logic frame_valid_o,
  output logic line_valid_o,
  output logic [iwft_pkg::PIX_W-1:0] pixel_o,
  output logic [iwft_pkg::FLD_W-1:0] array_row_o,
  output logic [iwft_pkg::CNT_W-1:0] array_col_o,
  output logic [iwft_pkg::FLD_W-1:0] exposure_rows_o
);
  import iwft_pkg::*;

  // PART_ID and SILICON_REV defaults are arbitrary values
  localparam logic [CNT_W-1:0] ARRAY_START_COLUMN_C = CNT_W'(ARRAY_START_COLUMN);
  localparam logic [CNT_W-1:0] DARK_ROWS_C = CNT_W'(DARK_BOTTOM_ROWS);

  function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    return v & m;
  endfunction

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    return idx == want;
  endfunction

  // Bus decode
  logic ack_reg;
  logic [31:0] dat_reg;
  wire [7:0] idx = wb_adr_i[ADR_IDX_MSB:ADR_IDX_LSB];
  wire req_new = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr_commit = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i;

  // Software copies
  logic [15:0] start_row_reg, start_col_reg, height_reg, width_reg;
  logic [15:0] line_blanking_reg, frame_blanking_rows_reg, exposure_reg, sync_reg;
  // Copies that steer the timing, loaded at frame boundaries
  logic [15:0] act_start_row_reg, act_start_col_reg, act_height_reg, act_width_reg;
  logic [15:0] act_line_blanking_reg, act_frame_blanking_rows_reg, act_exposure_src_reg;
  logic [CNT_W-1:0] col_reg, row_reg;
  logic [FLD_W-1:0] exposure_rows_reg;
  logic frame_valid_reg, line_valid_reg;
  logic [PIX_W-1:0] pixel_reg;
  logic [FLD_W-1:0] array_row_reg;
  logic [CNT_W-1:0] array_col_reg;
  // Window flags delayed to line up with the array address, so each flag meets the pixel it addressed
  logic rows_q, win_q;

  // Timing geometry
  wire [CNT_W-1:0] row_len = ARRAY_START_COLUMN_C + CNT_W'(act_line_blanking_reg[10:0]);
  wire [CNT_W-1:0] frame_rows = CNT_W'(act_height_reg[11:0]) + DARK_ROWS_C + CNT_W'(act_frame_blanking_rows_reg[11:0]);
  wire row_end = col_reg == row_len - CNT_W'(1);
  wire frame_end = row_end & (row_reg == frame_rows - CNT_W'(1));
  // [RULE6] height sets readout rows
  wire in_rows = row_reg < CNT_W'(act_height_reg[11:0]);
  wire [CNT_W-1:0] col_first = CNT_W'(act_start_col_reg[11:0]);
  wire [CNT_W-1:0] col_last = col_first + CNT_W'(act_width_reg[11:0]);
  // [RULE8] only window columns valid
  wire in_start_column = (col_reg >= col_first) & (col_reg < col_last) & (col_reg < ARRAY_START_COLUMN_C);
  // [RULE16] first bottom dark row
  wire tint_event = (row_reg == CNT_W'(act_height_reg[11:0])) & (col_reg == '0);
  // [RULE18] auto value overrides manual
  wire [FLD_W-1:0] tint_sel = auto_exposure_en_i ? auto_exposure_rows_i : act_exposure_src_reg[FLD_W-1:0];
  // [RULE23] hold bit blocks frame updates
  wire sync_load = frame_end & ~sync_reg[SYNC_HOLD_BIT];
  // [RULE3] readout row offset by start row
  wire [FLD_W-1:0] read_row = act_start_row_reg[FLD_W-1:0] + row_reg[FLD_W-1:0];

  // Read mux
  wire [15:0] rd_data =
    hit(idx, IDX_START_ROW) ? start_row_reg :
    hit(idx, IDX_START_COLUMN) ? start_col_reg :
    hit(idx, IDX_WINDOW_HEIGHT) ? height_reg :
    hit(idx, IDX_WINDOW_WIDTH) ? width_reg :
    hit(idx, IDX_LINE_BLANKING) ? line_blanking_reg :
    // [RULE12] revision readback
    hit(idx, IDX_SILICON_REVISION) ? {8'h00, SILICON_REV} :
    // [RULE11] identity and complement
    hit(idx, IDX_PART_IDENTITY) ? {8'h00, PART_ID} :
    hit(idx, IDX_PART_IDENTITY_INVERTED) ? {8'h00, ~PART_ID} :
    hit(idx, IDX_FRAME_BLANKING_ROWS) ? frame_blanking_rows_reg :
    hit(idx, IDX_EXPOSURE_ROWS) ? exposure_reg :
    hit(idx, IDX_SYNC_CTRL) ? sync_reg :
    // [RULE22] run-time status bytes
    hit(idx, IDX_REPLACED_PIXEL_COUNT) ? {8'h00, replaced_pixel_count_i} :
    // [RULE21] row MSBs
    hit(idx, IDX_CURRENT_OUTPUT_ROW) ? {8'h00, array_row_reg[FLD_W-1:ROW_MSB_LO]} :
    hit(idx, IDX_DARK_VARIANCE_HIGH) ? {8'h00, dark_variance_i[15:BYTE_HI_LSB]} :
    hit(idx, IDX_DARK_VARIANCE_LOW) ? {8'h00, dark_variance_i[7:0]} :
    hit(idx, IDX_ACTIVE_ROWS_HIGH) ? {8'h00, act_height_reg[15:BYTE_HI_LSB]} :
    hit(idx, IDX_ACTIVE_ROWS_LOW) ? {8'h00, act_height_reg[7:0]} :
    hit(idx, IDX_ACTIVE_COLUMNS_HIGH) ? {8'h00, act_width_reg[15:BYTE_HI_LSB]} :
    hit(idx, IDX_ACTIVE_COLUMNS_LOW) ? {8'h00, act_width_reg[7:0]} :
    hit(idx, IDX_COLUMN_COUNTER_HIGH) ? {8'h00, 2'b00, col_reg[CNT_W-1:BYTE_HI_LSB]} :
    hit(idx, IDX_COLUMN_COUNTER_LOW) ? {8'h00, col_reg[7:0]} :
    hit(idx, IDX_AUTO_EXPOSURE_ROWS_HIGH) ? {12'h000, auto_exposure_rows_i[FLD_W-1:BYTE_HI_LSB]} :
    hit(idx, IDX_AUTO_EXPOSURE_ROWS_LOW) ? {8'h00, auto_exposure_rows_i[7:0]} :
    16'h0000;

  // Bus slave: ack one cycle after the request, write at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req_new;
      dat_reg <= req_new ? {16'h0000, rd_data} : 32'h0000_0000;
    end
  end

  // Software registers; masks keep reserved bits at zero
  // [RULE24] reserved bits dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_row_reg <= RST_START_ROW;
      start_col_reg <= RST_START_COLUMN;
      height_reg <= RST_WINDOW_HEIGHT;
      width_reg <= RST_WINDOW_WIDTH;
      line_blanking_reg <= LINE_BLANK_RST & MASK_11;
      frame_blanking_rows_reg <= RST_FRAME_BLANKING_ROWS;
      exposure_reg <= RST_EXPOSURE_ROWS;
      sync_reg <= RST_SYNC_CTRL;
    end else if (wr_commit) begin
      // [RULE1] start row pair
      if (hit(idx, IDX_START_ROW)) start_row_reg <= wr_merge(start_row_reg, wb_dat_i, wb_sel_i, MASK_12);
      // [RULE2] start column pair
      if (hit(idx, IDX_START_COLUMN)) start_col_reg <= wr_merge(start_col_reg, wb_dat_i, wb_sel_i, MASK_12);
      // [RULE4] height pair
      if (hit(idx, IDX_WINDOW_HEIGHT)) height_reg <= wr_merge(height_reg, wb_dat_i, wb_sel_i, MASK_12);
      // [RULE7] width pair
      if (hit(idx, IDX_WINDOW_WIDTH)) width_reg <= wr_merge(width_reg, wb_dat_i, wb_sel_i, MASK_12);
      // [RULE9] eleven-bit blanking
      if (hit(idx, IDX_LINE_BLANKING)) line_blanking_reg <= wr_merge(line_blanking_reg, wb_dat_i, wb_sel_i, MASK_11);
      // [RULE13] frame blanking rows
      if (hit(idx, IDX_FRAME_BLANKING_ROWS)) frame_blanking_rows_reg <= wr_merge(frame_blanking_rows_reg, wb_dat_i, wb_sel_i, MASK_12);
      // [RULE15] exposure any time
      if (hit(idx, IDX_EXPOSURE_ROWS)) exposure_reg <= wr_merge(exposure_reg, wb_dat_i, wb_sel_i, MASK_12);
      if (hit(idx, IDX_SYNC_CTRL)) sync_reg <= wr_merge(sync_reg, wb_dat_i, wb_sel_i, MASK_SYNC);
    end
  end

  // [RULE23] frame-boundary shadow load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_start_row_reg <= RST_START_ROW;
      act_start_col_reg <= RST_START_COLUMN;
      act_height_reg <= RST_WINDOW_HEIGHT;
      act_width_reg <= RST_WINDOW_WIDTH;
      act_line_blanking_reg <= LINE_BLANK_RST & MASK_11;
      act_frame_blanking_rows_reg <= RST_FRAME_BLANKING_ROWS;
      act_exposure_src_reg <= RST_EXPOSURE_ROWS;
    end else if (sync_load) begin
      act_start_row_reg <= start_row_reg;
      act_start_col_reg <= start_col_reg;
      act_height_reg <= height_reg;
      act_width_reg <= width_reg;
      act_line_blanking_reg <= line_blanking_reg;
      act_frame_blanking_rows_reg <= frame_blanking_rows_reg;
      act_exposure_src_reg <= exposure_reg;
    end
  end

  // [RULE13] blanking rows lengthen the frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_reg <= '0;
      row_reg <= '0;
    end else begin
      col_reg <= row_end ? '0 : col_reg + CNT_W'(1);
      row_reg <= frame_end ? '0 : (row_end ? row_reg + CNT_W'(1) : row_reg);
    end
  end

  // [RULE16] exposure sampled once per frame
  // [RULE20] decrease never splits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exposure_rows_reg <= RST_EXPOSURE_ROWS[FLD_W-1:0];
    end else if (tint_event) begin
      exposure_rows_reg <= tint_sel;
    end
  end

  // Pixel stream: address one cycle behind the counters, flags and pixel one cycle more
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rows_q <= 1'b0;
      win_q <= 1'b0;
      frame_valid_reg <= 1'b0;
      line_valid_reg <= 1'b0;
      pixel_reg <= '0;
      array_row_reg <= '0;
      array_col_reg <= '0;
    end else begin
      rows_q <= in_rows;
      win_q <= in_rows & in_start_column;
      frame_valid_reg <= rows_q;
      line_valid_reg <= win_q;
      // [RULE3] pixel of addressed column
      pixel_reg <= win_q ? pixel_i : '0;
      array_row_reg <= read_row;
      array_col_reg <= col_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign frame_valid_o = frame_valid_reg;
  assign line_valid_o = line_valid_reg;
  assign pixel_o = pixel_reg;
  assign array_row_o = array_row_reg;
  assign array_col_o = array_col_reg;
  assign exposure_rows_o = exposure_rows_reg;

  // Assertions
  sequence s_req;
    wb_cyc_i && wb_stb_i && !ack_reg;
  endsequence
  sequence s_ack_once;
    ack_reg ##1 !ack_reg;
  endsequence

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) s_req |=> s_ack_once;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse after request");

  property p_reset_start;
    @(posedge clk_i) $past(rst_i) |-> (start_row_reg == RST_START_ROW) && (start_col_reg == RST_START_COLUMN);
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("start corner reset wrong"); // [RULE1]

  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
      (height_reg[15:FLD_W] == 4'h0) && (width_reg[15:FLD_W] == 4'h0) && (line_blanking_reg[15:11] == 5'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // [RULE24]

  property p_ident_inv;
    @(posedge clk_i) disable iff (rst_i)
      s_req ##0 (idx == IDX_PART_IDENTITY_INVERTED) |=> wb_dat_o == {24'h000000, ~PART_ID};
  endproperty
  a_ident_inv: assert property (p_ident_inv) else $error("identity complement wrong"); // [RULE11]

  property p_tint_sample;
    @(posedge clk_i) disable iff (rst_i) tint_event |=> exposure_rows_reg == $past(tint_sel);
  endproperty
  a_tint_sample: assert property (p_tint_sample) else $error("exposure not sampled at dark row"); // [RULE16]

  property p_tint_hold;
    @(posedge clk_i) disable iff (rst_i) !tint_event |=> $stable(exposure_rows_reg);
  endproperty
  a_tint_hold: assert property (p_tint_hold) else $error("exposure changed off the sample point"); // [RULE16]

  property p_auto_wins;
    @(posedge clk_i) disable iff (rst_i)
      tint_event && auto_exposure_en_i |=> exposure_rows_reg == $past(auto_exposure_rows_i);
  endproperty
  a_auto_wins: assert property (p_auto_wins) else $error("manual exposure used under auto"); // [RULE18]

  property p_row_wrap;
    @(posedge clk_i) disable iff (rst_i) row_end |=> col_reg == '0;
  endproperty
  a_row_wrap: assert property (p_row_wrap) else $error("row length wrong"); // [RULE8]

  property p_line_in_frame;
    @(posedge clk_i) disable iff (rst_i) line_valid_reg |-> frame_valid_reg;
  endproperty
  a_line_in_frame: assert property (p_line_in_frame) else $error("line valid outside frame"); // [RULE3]

  property p_shadow_stable;
    @(posedge clk_i) disable iff (rst_i) !frame_end |=> $stable(act_height_reg) && $stable(act_frame_blanking_rows_reg);
  endproperty
  a_shadow_stable: assert property (p_shadow_stable) else $error("config changed mid frame"); // [RULE23]

  property p_frame_rows;
    @(posedge clk_i) disable iff (rst_i) frame_end |=> row_reg == '0 && col_reg == '0;
  endproperty
  a_frame_rows: assert property (p_frame_rows) else $error("frame did not restart"); // [RULE6]

  sequence s_quiet_pixel;
    !line_valid_reg && (pixel_reg == '0);
  endsequence

  property p_pixel_gate;
    @(posedge clk_i) disable iff (rst_i) !win_q |=> s_quiet_pixel;
  endproperty
  a_pixel_gate: assert property (p_pixel_gate) else $error("pixel driven outside the window"); // [RULE8]

  property p_pixel_pass;
    @(posedge clk_i) disable iff (rst_i) win_q |=> pixel_reg == $past(pixel_i);
  endproperty
  a_pixel_pass: assert property (p_pixel_pass) else $error("pixel does not match its address"); // [RULE3]

  property p_col_window;
    @(posedge clk_i) disable iff (rst_i) win_q |-> (array_col_reg >= col_first) && (array_col_reg < col_last);
  endproperty
  a_col_window: assert property (p_col_window) else $error("window column out of range"); // [RULE8]

  property p_row_origin;
    @(posedge clk_i) disable iff (rst_i) $rose(rows_q) |-> array_row_reg == act_start_row_reg[FLD_W-1:0];
  endproperty
  a_row_origin: assert property (p_row_origin) else $error("window did not open at the start row"); // [RULE3]

  property p_reserved_zero_more;
    @(posedge clk_i) disable iff (rst_i)
      (start_row_reg[15:FLD_W] == 4'h0) && (start_col_reg[15:FLD_W] == 4'h0) &&
      (frame_blanking_rows_reg[15:FLD_W] == 4'h0) && (exposure_reg[15:FLD_W] == 4'h0);
  endproperty
  a_reserved_zero_more: assert property (p_reserved_zero_more) else $error("reserved bits set"); // [RULE24]

  property p_write_lands;
    @(posedge clk_i) disable iff (rst_i)
      wr_commit && (idx == IDX_EXPOSURE_ROWS) && wb_sel_i[0] |=> exposure_reg[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("exposure write lost"); // [RULE15]

  property p_hold_blocks;
    @(posedge clk_i) disable iff (rst_i)
      frame_end && sync_reg[SYNC_HOLD_BIT] |=> $stable(act_exposure_src_reg) && $stable(act_width_reg);
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("held config loaded"); // [RULE23]

  property p_col_bound;
    @(posedge clk_i) disable iff (rst_i) col_reg < row_len;
  endproperty
  a_col_bound: assert property (p_col_bound) else $error("column counter past row length"); // [RULE8]

  property p_row_bound;
    @(posedge clk_i) disable iff (rst_i) row_reg < frame_rows;
  endproperty
  a_row_bound: assert property (p_row_bound) else $error("row counter past frame length"); // [RULE13]

endmodule
`default_nettype wire

// ==== test/iwft_capture_model.sv ====
`default_nettype none
module iwft_capture_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_valid_i,
  input wire logic line_valid_i,
  input wire logic [iwft_pkg::PIX_W-1:0] pixel_i,
  input wire logic [iwft_pkg::FLD_W-1:0] array_row_i,
  input wire logic [iwft_pkg::CNT_W-1:0] array_col_i,
  output logic [iwft_pkg::PIX_W-1:0] array_pixel_o,
  output logic [15:0] frame_period_o,
  output logic [15:0] rows_seen_o,
  output logic [15:0] pixels_seen_o,
  output logic [iwft_pkg::PIX_W-1:0] first_pixel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import iwft_pkg::*;
  logic fv_q, lv_q;
  logic [15:0] cyc_cnt, row_cnt, pix_cnt;
  // Each array pixel carries the low six bits of its row and column, so the captured corner shows the window origin
  assign array_pixel_o = {array_row_i[5:0], array_col_i[5:0]};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fv_q <= 1'b0;
      lv_q <= 1'b0;
      cyc_cnt <= 16'h0000;
      row_cnt <= 16'h0000;
      pix_cnt <= 16'h0000;
    end else begin
      fv_q <= frame_valid_i;
      lv_q <= line_valid_i;
      cyc_cnt <= cyc_cnt + 16'h0001;
      if (frame_valid_i && !fv_q) begin
        frame_period_o <= cyc_cnt;
        cyc_cnt <= 16'h0001;
      end
      if (!frame_valid_i && fv_q) begin
        rows_seen_o <= row_cnt;
        row_cnt <= 16'h0000;
      end
      if (line_valid_i && !lv_q) begin
        row_cnt <= row_cnt + 16'h0001;
        if (row_cnt == 16'h0000) begin
          first_pixel_o <= pixel_i;
        end
      end
      if (line_valid_i) begin
        pix_cnt <= pix_cnt + 16'h0001;
      end else if (lv_q) begin
        pixels_seen_o <= pix_cnt;
        pix_cnt <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/image_window_frame_timing_regs_test.sv ====
`default_nettype none
module image_window_frame_timing_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import iwft_pkg::*;
  // Arbitrary identity values
  localparam logic [7:0] ID_CODE = 8'h3C;
  localparam logic [7:0] REV_CODE = 8'h07;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, auto_en = 1'b0;
  logic [31:0] wb_adr = '0, wb_dat = '0, wb_dat_o;
  logic [3:0] wb_sel = '0;
  logic [FLD_W-1:0] auto_rows = '0, arow, exp_rows;
  logic [7:0] repl = '0;
  logic [15:0] dark_var = '0, period, rows_seen, pix_seen, q;
  logic [PIX_W-1:0] pix_in, pix_out, first_pix;
  logic [CNT_W-1:0] acol;
  logic wb_ack_o, fv, lv;
  int errors = 0, tests_run = 0;
  logic [7:0] ridx [10] = '{IDX_START_ROW, IDX_START_COLUMN, IDX_WINDOW_HEIGHT, IDX_WINDOW_WIDTH,
    IDX_LINE_BLANKING, IDX_PART_IDENTITY, IDX_SILICON_REVISION, IDX_FRAME_BLANKING_ROWS,
    IDX_EXPOSURE_ROWS, IDX_PART_IDENTITY_INVERTED};
  logic [15:0] rval [10] = '{16'h000C, 16'h000C, 16'h0613, 16'h0813, 16'h0004, {8'h00, ID_CODE},
    {8'h00, REV_CODE}, 16'h0010, 16'h00F0, {8'h00, ~ID_CODE}};

  initial forever #5 clk_i = ~clk_i;

  iwft_timing_regs #(.ARRAY_START_COLUMN(16), .DARK_BOTTOM_ROWS(4), .LINE_BLANK_RST(16'h0004),
    .PART_ID(ID_CODE), .SILICON_REV(REV_CODE)) i_iwft_timing_regs (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .auto_exposure_en_i(auto_en), .auto_exposure_rows_i(auto_rows), .replaced_pixel_count_i(repl),
    .dark_variance_i(dark_var), .pixel_i(pix_in), .frame_valid_o(fv), .line_valid_o(lv),
    .pixel_o(pix_out), .array_row_o(arow), .array_col_o(acol), .exposure_rows_o(exp_rows));

  iwft_capture_model i_iwft_capture_model (
    .clk_i(clk_i), .rst_i(rst_i), .frame_valid_i(fv), .line_valid_i(lv), .pixel_i(pix_out),
    .array_row_i(arow), .array_col_i(acol), .array_pixel_o(pix_in), .frame_period_o(period),
    .rows_seen_o(rows_seen), .pixels_seen_o(pix_seen), .first_pixel_o(first_pix));

  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request is held until ack is sampled high, then released for at least one cycle
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [15:0] d, input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {22'h000000, idx, 2'b00};
    wb_dat <= {16'h0000, d};
    wb_sel <= sel;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    xfer(1'b1, idx, d, 4'h3);
  endtask

  task automatic rd(input string name, input logic [7:0] idx, input logic [15:0] exp);
    xfer(1'b0, idx, 16'h0000, 4'hF);
    check(name, exp, q);
  endtask

  // Counts frame starts; the first frame after reset runs long at default size
  task automatic frames(input int n);
    int k;
    k = 0;
    repeat (n) begin
      while (fv !== 1'b0 && k < 40000) begin
        @(posedge clk_i);
        k++;
      end
      while (fv !== 1'b1 && k < 40000) begin
        @(posedge clk_i);
        k++;
      end
    end
    if (k >= 40000) begin
      errors++;
    end
    // The capture model updates at the edge that shows the rise; let it settle
    @(posedge clk_i);
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) rd("reset value", ridx[i], rval[i]);
    check("exposure out", 16'h00F0, {4'h0, exp_rows});
    wr(IDX_START_ROW, 16'hFFFF);
    rd("start row", IDX_START_ROW, 16'h0FFF);
    xfer(1'b1, IDX_START_COLUMN, 16'h0599, 4'h2);
    rd("start column", IDX_START_COLUMN, 16'h050C);
    wr(IDX_LINE_BLANKING, 16'hFFFF);
    rd("line blanking", IDX_LINE_BLANKING, 16'h07FF);
    wr(IDX_PART_IDENTITY, 16'h00FF);
    rd("identity", IDX_PART_IDENTITY, {8'h00, ID_CODE});
    rd("unmapped", 8'h01, 16'h0000);
    repl <= 8'hA7;
    dark_var <= 16'hC35A;
    rd("replaced pixels", IDX_REPLACED_PIXEL_COUNT, 16'h00A7);
    rd("variance high", IDX_DARK_VARIANCE_HIGH, 16'h00C3);
    rd("variance low", IDX_DARK_VARIANCE_LOW, 16'h005A);
    rd("column count high", IDX_COLUMN_COUNTER_HIGH, 16'h0000);
    wr(IDX_START_ROW, 16'h0300);
    wr(IDX_START_COLUMN, 16'h0003);
    wr(IDX_WINDOW_HEIGHT, 16'h0004);
    wr(IDX_WINDOW_WIDTH, 16'h0004);
    wr(IDX_LINE_BLANKING, 16'h0004);
    wr(IDX_FRAME_BLANKING_ROWS, 16'h0008);
    wr(IDX_EXPOSURE_ROWS, 16'h0064);
    frames(3);
    check("frame period", 16'h0140, period);
    check("rows", 16'h0004, rows_seen);
    check("pixels", 16'h0004, pix_seen);
    check("first pixel", 16'h0003, {4'h0, first_pix});
    check("exposure out", 16'h0064, {4'h0, exp_rows});
    rd("active rows", IDX_ACTIVE_ROWS_LOW, 16'h0004);
    rd("active columns", IDX_ACTIVE_COLUMNS_LOW, 16'h0004);
    rd("current row", IDX_CURRENT_OUTPUT_ROW, 16'h0030);
    wr(IDX_WINDOW_HEIGHT, 16'h0006);
    frames(2);
    check("frame period", 16'h0168, period);
    check("rows", 16'h0006, rows_seen);
    wr(IDX_WINDOW_WIDTH, 16'h0008);
    frames(2);
    check("frame period", 16'h0168, period);
    check("pixels", 16'h0008, pix_seen);
    wr(IDX_FRAME_BLANKING_ROWS, 16'h000A);
    frames(2);
    check("frame period", 16'h0190, period);
    wr(IDX_SYNC_CTRL, 16'h0001);
    rd("sync hold", IDX_SYNC_CTRL, 16'h0001);
    wr(IDX_EXPOSURE_ROWS, 16'h006E);
    frames(2);
    check("exposure out", 16'h0064, {4'h0, exp_rows});
    wr(IDX_SYNC_CTRL, 16'h0000);
    frames(2);
    check("exposure out", 16'h006E, {4'h0, exp_rows});
    auto_rows <= 12'h04D;
    auto_en <= 1'b1;
    frames(2);
    check("exposure out", 16'h004D, {4'h0, exp_rows});
    rd("auto exposure low", IDX_AUTO_EXPOSURE_ROWS_LOW, 16'h004D);
    give_verdict();
  end
endmodule
`default_nettype wire
